// >>> hw/rx_strength_status.sv
// receive strength computation, output rate selection and serial frame out.
// assumes samples arrive already offset-corrected and synchronous to core_clk,
// and that the agc logic supplies gain, gain step events and lna mode.
`timescale 1ns/10ps

// ------------------------------------------------------------
// frame fifo
// ------------------------------------------------------------
module frame_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign outData  = mem[rdPtr_ff[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (doWrite) wrPtr_ff <= wrPtr_ff + 1'b1;
            if (doRead) rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end

    // storage needs no reset: only entries between pointers are read
    always_ff @(posedge core_clk) begin
        if (doWrite) mem[wrPtr_ff[AW-1:0]] <= inData;
    end
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module rx_strength_status #(
    parameter int SAMPLE_W = strength_pkg::SAMPLE_BITS,
    parameter int DEPTH    = strength_pkg::FIFO_DEPTH
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    // register port
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrEn,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regRdEn,
    output logic      [7:0]          regRdData,
    // corrected samples from the channel filter
    input  wire logic                sampleValid,
    input  wire logic [SAMPLE_W-1:0] sampleI,
    input  wire logic [SAMPLE_W-1:0] sampleQ,
    // agc side
    input  wire logic [5:0]          pgaGainI,
    input  wire logic [5:0]          pgaGainQ,
    input  wire logic                lnaLowGain,
    input  wire logic                gainUpEvt,
    input  wire logic                gainDownEvt,
    input  wire logic                gainHoldPin,
    input  wire logic [4:0]          testFlags,
    output logic                     gainHold,
    output logic                     gainApply,
    // serial frame link
    input  wire logic                linkReady,
    output logic                     serValid,
    output logic                     serData,
    output logic                     serFirst,
    output logic                     frameDropped
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] agcOne_ff, agcThree_ff, chFilter_ff, strCfg_ff, statusEn_ff;
    logic [7:0] result_ff;
    logic [7:0] regRdData_ff;

    wire wrAgcOne   = regWrEn && regAddr == strength_pkg::ADDR_AGC_CONTROL_ONE;
    wire wrAgcThree = regWrEn && regAddr == strength_pkg::ADDR_AGC_CONTROL_THREE;
    wire wrChFilter = regWrEn && regAddr == strength_pkg::ADDR_CHFILT;
    wire wrStrCfg   = regWrEn && regAddr == strength_pkg::ADDR_STRCFG;
    wire wrStatusEn = regWrEn && regAddr == strength_pkg::ADDR_STATUS_EN;

    wire [1:0] holdMode  = agcThree_ff[strength_pkg::HOLD_MODE_LSB +: 2];
    wire [1:0] rateSel   = chFilter_ff[strength_pkg::RATE_SEL_LSB +: 2];
    wire [3:0] choice    = chFilter_ff[strength_pkg::CHOICE_LSB +: 4];
    wire [1:0] corrSel   = strCfg_ff[strength_pkg::CORR_SEL_LSB +: 2];
    wire [2:0] avgSel    = strCfg_ff[strength_pkg::AVG_CNT_LSB +: 3];

    // unmapped offsets read as zero
    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            strength_pkg::ADDR_AGC_CONTROL_ONE:      rdMux = agcOne_ff;
            strength_pkg::ADDR_AGC_CONTROL_THREE:      rdMux = agcThree_ff;
            strength_pkg::ADDR_CHFILT:    rdMux = chFilter_ff;
            strength_pkg::ADDR_STRCFG:    rdMux = strCfg_ff;
            strength_pkg::ADDR_GAIN_I:    rdMux = {1'b0, lnaLowGain, pgaGainI};
            strength_pkg::ADDR_GAIN_Q:    rdMux = {2'b00, pgaGainQ};
            strength_pkg::ADDR_RESULT:    rdMux = result_ff;
            strength_pkg::ADDR_STATUS_EN: rdMux = statusEn_ff;
            default:                      rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            agcOne_ff    <= strength_pkg::RST_AGC_CONTROL_ONE;
            agcThree_ff  <= strength_pkg::RST_AGC_CONTROL_THREE;
            chFilter_ff  <= strength_pkg::RST_CHFILT;
            strCfg_ff    <= strength_pkg::RST_STRCFG;
            statusEn_ff  <= strength_pkg::RST_STATUS_EN;
            regRdData_ff <= 8'h00;
        end else begin
            if (wrAgcOne) agcOne_ff <= regWrData;
            if (wrAgcThree) agcThree_ff <= regWrData;
            if (wrChFilter) chFilter_ff <= regWrData;
            if (wrStrCfg) strCfg_ff <= regWrData;
            if (wrStatusEn) statusEn_ff <= regWrData;
            if (regRdEn) regRdData_ff <= rdMux;
        end
    end
    assign regRdData = regRdData_ff;

    // ------------------------------------------------------------
    // sample rates
    // ------------------------------------------------------------
    // filter codes above 9 are undefined; they fall back to the slowest base
    wire [11:0] baseDiv = (choice < strength_pkg::FIRST_MID_CHOICE)  ? strength_pkg::DIV_FAST :
                          (choice < strength_pkg::FIRST_SLOW_CHOICE) ? strength_pkg::DIV_MID :
                                                                       strength_pkg::DIV_SLOW;
    logic [11:0] baseCnt_ff;
    logic [1:0]  decCnt_ff;
    wire         baseTick = baseCnt_ff == baseDiv - 12'h001;
    // reduced rates on fast filters still run, aliasing is the user's concern
    wire [1:0]   decMask  = rateSel == 2'b00 ? 2'b00 : (rateSel == 2'b01 ? 2'b01 : 2'b11);
    wire         outTick  = baseTick && ((decCnt_ff & decMask) == 2'b00);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            baseCnt_ff <= 12'h000;
            decCnt_ff  <= 2'b00;
        end else begin
            baseCnt_ff <= baseTick || baseCnt_ff >= baseDiv ? 12'h000 : baseCnt_ff + 12'h001;
            if (baseTick) decCnt_ff <= decCnt_ff + 2'b01;
        end
    end

    // ------------------------------------------------------------
    // power detector and strength code
    // ------------------------------------------------------------
    logic [SAMPLE_W-1:0] latI_ff, latQ_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latI_ff <= '0;
            latQ_ff <= '0;
        end else if (sampleValid) begin
            latI_ff <= sampleI;
            latQ_ff <= sampleQ;
        end
    end

    wire [SAMPLE_W-1:0] absI = latI_ff[SAMPLE_W-1] ? SAMPLE_W'(-latI_ff) : latI_ff;
    wire [SAMPLE_W-1:0] absQ = latQ_ff[SAMPLE_W-1] ? SAMPLE_W'(-latQ_ff) : latQ_ff;
    wire [SAMPLE_W-1:0] mag  = absI > absQ ? absI : absQ;

    // coarse log: 12 half-dB codes per octave plus three mantissa bits
    logic [4:0] msbPos;
    logic [2:0] mant;
    always_comb begin
        msbPos = 5'h00;
        mant   = 3'h0;
        for (int b = 3; b < SAMPLE_W; b++) begin
            if (mag[b]) begin
                msbPos = 5'(b);
                mant   = mag[b-1 -: 3];
            end
        end
    end
    wire [12:0] detCode  = 13'(msbPos) * strength_pkg::LOG_STEP + 13'(mant) + 13'(mant >> 1);
    // gain code counts half-dB below maximum gain
    wire [12:0] gainCode = 13'(strength_pkg::MAX_PGA_CODE - pgaGainI) << 1;
    logic [5:0] corrDb;
    always_comb begin
        case (corrSel)
            2'b00:   corrDb = strength_pkg::CORR_DB_00;
            2'b01:   corrDb = strength_pkg::CORR_DB_01;
            2'b10:   corrDb = strength_pkg::CORR_DB_10;
            default: corrDb = strength_pkg::CORR_DB_11;
        endcase
    end

    // ------------------------------------------------------------
    // averaging and result
    // ------------------------------------------------------------
    logic [20:0] avgSum_ff;
    logic [7:0]  avgCnt_ff;
    wire  [7:0]  avgLast = 8'((9'h001 << avgSel) - 9'h001);
    wire  [20:0] sumNext = avgSum_ff + 21'(detCode);
    wire  [12:0] avgDet  = 13'(sumNext >> avgSel);
    // signed arithmetic in 14 bits, then clamp to the 8-bit result
    wire  [13:0] rawCode = 14'(avgDet) + 14'(gainCode) + 14'(strength_pkg::CAL_OFFSET)
                           - 14'({corrDb, 1'b0});
    wire  [7:0]  satCode = rawCode[13] ? 8'h00 : (rawCode > 14'h00ff ? 8'hff : rawCode[7:0]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            avgSum_ff <= '0;
            avgCnt_ff <= 8'h00;
            result_ff <= 8'h00;
        end else if (baseTick) begin
            if (avgCnt_ff >= avgLast) begin
                avgSum_ff <= '0;
                avgCnt_ff <= 8'h00;
                result_ff <= satCode;
            end else begin
                avgSum_ff <= sumNext;
                avgCnt_ff <= avgCnt_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // gain hold and gain step flags
    // ------------------------------------------------------------
    assign gainHold = agcOne_ff[strength_pkg::HOLD_SEL_BIT] ? agcOne_ff[strength_pkg::HOLD_REG_BIT]
                                                            : gainHoldPin;
    logic holdDly_ff, pendUp_ff, pendDown_ff, flagUp_ff, flagDown_ff;
    wire  holdRise   = gainHold && !holdDly_ff;
    wire  holdFall   = !gainHold && holdDly_ff;
    wire  deferMode  = holdMode == 2'b01;
    // mode 00 and 1x flag at the change itself, mode 01 at hold onset
    wire  setUp      = deferMode ? holdRise && pendUp_ff : gainUpEvt;
    wire  setDown    = deferMode ? holdRise && pendDown_ff : gainDownEvt;
    assign gainApply = deferMode && holdFall && (pendUp_ff || pendDown_ff);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            holdDly_ff  <= 1'b0;
            pendUp_ff   <= 1'b0;
            pendDown_ff <= 1'b0;
            flagUp_ff   <= 1'b0;
            flagDown_ff <= 1'b0;
        end else begin
            holdDly_ff <= gainHold;
            // pending change is recognised only while hold is off
            if (deferMode && !gainHold && gainUpEvt) pendUp_ff <= 1'b1;
            else if (gainApply || !deferMode) pendUp_ff <= 1'b0;
            if (deferMode && !gainHold && gainDownEvt) pendDown_ff <= 1'b1;
            else if (gainApply || !deferMode) pendDown_ff <= 1'b0;
            // flags live for one output sample; a new event wins over the clear
            if (setUp) flagUp_ff <= 1'b1;
            else if (outTick) flagUp_ff <= 1'b0;
            if (setDown) flagDown_ff <= 1'b1;
            else if (outTick) flagDown_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status word and frame
    // ------------------------------------------------------------
    wire [5:0]  lowBits = result_ff[7:6] != 2'b00 ? 6'h3f : result_ff[5:0];
    wire [15:0] rawStatus = {2'b00, testFlags[4:1], lnaLowGain,
                             flagUp_ff, flagDown_ff, lowBits, testFlags[0]};
    // enable register bit for status positions 13 to 0; positions 15 and 14 are never enabled
    wire [15:0] enMap = {2'b00, statusEn_ff[7:4],
                         statusEn_ff[strength_pkg::EN_LOW_GAIN],
                         {2{statusEn_ff[strength_pkg::EN_GAIN_STEP]}},
                         {6{statusEn_ff[strength_pkg::EN_STRENGTH]}},
                         statusEn_ff[0]};
    logic [15:0] status;
    genvar s;
    generate
        for (s = 0; s < 16; s++) begin : g_mask
            assign status[s] = rawStatus[s] & enMap[s];
        end
    endgenerate

    logic        pendValid_ff, dropped_ff;
    logic [63:0] pendFrame_ff;
    wire         fifoInReady;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pendValid_ff <= 1'b0;
            pendFrame_ff <= '0;
            dropped_ff   <= 1'b0;
        end else begin
            if (outTick) begin
                pendValid_ff <= 1'b1;
                pendFrame_ff <= {latI_ff, latQ_ff, status};
            end else if (fifoInReady) begin
                pendValid_ff <= 1'b0;
            end
            // a frame still waiting when the next sample comes is overwritten
            if (outTick && pendValid_ff && !fifoInReady) dropped_ff <= 1'b1;
            else if (wrStatusEn) dropped_ff <= 1'b0;
        end
    end
    assign frameDropped = dropped_ff;

    wire        fifoOutValid;
    wire [63:0] fifoOutData;
    logic       fifoOutReady;
    frame_fifo #(
        .WIDTH (strength_pkg::FRAME_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (pendValid_ff),
        .inReady  (fifoInReady),
        .inData   (pendFrame_ff),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // ------------------------------------------------------------
    // serialiser
    // ------------------------------------------------------------
    strength_pkg::shift_state_e state_ff, nxt_state;
    logic [63:0] shiftReg_ff;
    logic [5:0]  bitCnt_ff;
    logic        first_ff;
    wire         lastBit = bitCnt_ff == 6'h3f;

    always_comb begin
        nxt_state    = state_ff;
        fifoOutReady = 1'b0;
        case (state_ff)
            strength_pkg::SHIFT_IDLE: begin
                fifoOutReady = 1'b1;
                if (fifoOutValid) nxt_state = strength_pkg::SHIFT_BUSY;
            end
            strength_pkg::SHIFT_BUSY: begin
                if (linkReady && lastBit) nxt_state = strength_pkg::SHIFT_IDLE;
            end
            default: nxt_state = strength_pkg::SHIFT_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff    <= strength_pkg::SHIFT_IDLE;
            shiftReg_ff <= '0;
            bitCnt_ff   <= 6'h00;
            first_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == strength_pkg::SHIFT_IDLE && fifoOutValid) begin
                shiftReg_ff <= fifoOutData;
                bitCnt_ff   <= 6'h00;
                first_ff    <= 1'b1;
            end else if (state_ff == strength_pkg::SHIFT_BUSY && linkReady) begin
                shiftReg_ff <= {shiftReg_ff[62:0], 1'b0};
                bitCnt_ff   <= bitCnt_ff + 6'h01;
                first_ff    <= 1'b0;
            end
        end
    end
    assign serValid = state_ff == strength_pkg::SHIFT_BUSY;
    assign serData  = shiftReg_ff[63];
    assign serFirst = serValid && first_ff;
endmodule

// >>> pkg/strength_pkg.sv
// Notes on behaviour
// - strength measured on offset-corrected samples
// - average log power at base rate
// - strength = detector + gain code - correction
// - gain code zero at maximum PGA gain
// - 8-bit result readable at 0x3A
// - code = 2*(dBm - correction) + 290
// - correction select 00 means 18 dB
// - rate select decimates: full, half, quarter
// - codes 0-3 run TCXO/128, reduced rates alias
// - codes 4-8 /256, code 9 /512 base
// - 64-bit frame: I24, Q24, status16
// - status bits zero unless enabled at 0x4B
// - S9 high while LNA in low gain
// - S8 one output sample on gain increase
// - hold mode 00 flags at gain change
// - hold mode 01 flags at hold, applies at release
// - S7 same for gain decrease
// - S6-S1 low result bits, saturating
// - result updates at averaging rate
// - hold from register bit or pin, selectable
//
// shared constants of the receive strength and status readout.
// assumes the core clock is the reference oscillator clock.
package strength_pkg;
    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_AGC_CONTROL_ONE      = 8'h1f;
    localparam logic [7:0] ADDR_AGC_CONTROL_THREE      = 8'h21;
    localparam logic [7:0] ADDR_CHFILT    = 8'h22;
    localparam logic [7:0] ADDR_STRCFG    = 8'h2c;
    localparam logic [7:0] ADDR_GAIN_I    = 8'h2f;
    localparam logic [7:0] ADDR_GAIN_Q    = 8'h30;
    localparam logic [7:0] ADDR_RESULT    = 8'h3a;
    localparam logic [7:0] ADDR_STATUS_EN = 8'h4b;
    localparam logic [7:0] RST_AGC_CONTROL_ONE       = 8'h01;
    localparam logic [7:0] RST_AGC_CONTROL_THREE       = 8'h00;
    localparam logic [7:0] RST_CHFILT     = 8'h00;
    localparam logic [7:0] RST_STRCFG     = 8'h00;
    localparam logic [7:0] RST_STATUS_EN  = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HOLD_SEL_BIT   = 2;
    localparam int HOLD_REG_BIT   = 1;
    localparam int HOLD_MODE_LSB  = 3;
    localparam int RATE_SEL_LSB   = 6;
    localparam int CHOICE_LSB     = 0;
    localparam int CORR_SEL_LSB   = 3;
    localparam int AVG_CNT_LSB    = 0;
    localparam int EN_LOW_GAIN    = 3;
    localparam int EN_GAIN_STEP   = 2;
    localparam int EN_STRENGTH    = 1;
    // ------------------------------------------------------------
    // rates, strength arithmetic, frame
    // ------------------------------------------------------------
    localparam logic [11:0] DIV_FAST = 12'h080;
    localparam logic [11:0] DIV_MID  = 12'h100;
    localparam logic [11:0] DIV_SLOW = 12'h200;
    localparam logic [3:0]  FIRST_MID_CHOICE  = 4'h4;
    localparam logic [3:0]  FIRST_SLOW_CHOICE = 4'h9;
    localparam logic [5:0]  CORR_DB_00 = 6'h12;
    localparam logic [5:0]  CORR_DB_01 = 6'h0c;
    localparam logic [5:0]  CORR_DB_10 = 6'h06;
    localparam logic [5:0]  CORR_DB_11 = 6'h00;
    localparam logic [12:0] CAL_OFFSET = 13'h0122;
    localparam logic [12:0] LOG_STEP   = 13'h000c;
    localparam logic [5:0]  MAX_PGA_CODE = 6'h30;
    localparam int FRAME_BITS  = 64;
    localparam int SAMPLE_BITS = 24;
    localparam int FIFO_DEPTH  = 4;

    typedef enum logic [1:0] {
        SHIFT_IDLE = 2'b01,
        SHIFT_BUSY = 2'b10
    } shift_state_e;
endpackage

// >>> bench/rx_strength_status_properties.sv
// port checker for the strength and status readout.
// assumes it is bound onto rx_strength_status.
`timescale 1ns/10ps
module rx_strength_status_chk (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [5:0] pgaGainI,
    input wire logic [5:0] pgaGainQ,
    input wire logic       lnaLowGain,
    input wire logic       gainHoldPin,
    input wire logic       gainHold,
    input wire logic       linkReady,
    input wire logic       serValid,
    input wire logic       serData,
    input wire logic       serFirst
);
    // ----
    // helper state
    // ----
    logic [6:0] bitCnt_ff;
    logic [1:0] hold_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bitCnt_ff <= 7'h00;
            hold_ff   <= 2'h0;
        end else begin
            if (serValid && linkReady) bitCnt_ff <= serFirst ? 7'h01 : bitCnt_ff + 7'h01;
            if (regWrEn && regAddr == 8'h1f) hold_ff <= regWrData[2:1];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    gain_read_i_a: assert property (regRdEn && regAddr == 8'h2f |=>
        regRdData == {1'b0, $past(lnaLowGain), $past(pgaGainI)}) else $error("gain i readback wrong");
    gain_read_q_a: assert property (regRdEn && regAddr == 8'h30 |=>
        regRdData == {2'b00, $past(pgaGainQ)}) else $error("gain q readback wrong");
    unmapped_read_a: assert property (regRdEn && regAddr == 8'h55 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!regRdEn |=> $stable(regRdData)) else $error("read data moved");
    hold_source_a: assert property (gainHold == (hold_ff[1] ? hold_ff[0] : gainHoldPin))
        else $error("hold source wrong");
    frame_start_a: assert property ($rose(serValid) |-> serFirst) else $error("frame start unmarked");
    bit_stall_a: assert property (serValid && !linkReady |=> serValid && $stable(serData))
        else $error("bit moved while stalled");
    frame_len_a: assert property ($fell(serValid) |-> bitCnt_ff == 7'h40)
        else $error("frame not 64 bits");
endmodule
bind rx_strength_status rx_strength_status_chk chk_u (.core_clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .pgaGainI, .pgaGainQ, .lnaLowGain, .gainHoldPin, .gainHold, .linkReady, .serValid, .serData,
    .serFirst);

// >>> bench/link_sink.sv
// modem model taking serial frames off the link.
// assumes pace comes from the bench: 0 ready, 1 every other cycle, 2 stalled.
`timescale 1ns/10ps
module link_sink (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [1:0]  pace,
    input  wire logic        serValid,
    input  wire logic        serData,
    input  wire logic        serFirst,
    output logic             linkReady,
    output logic      [63:0] frameWord,
    output int               frameCount
);
    logic [63:0] shift_ff;
    logic [6:0]  cnt_ff;
    logic        tog_ff;
    assign linkReady = (pace == 2'h0) || (pace == 2'h1 && tog_ff);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tog_ff     <= 1'b0;
            cnt_ff     <= 7'h00;
            frameCount <= 0;
        end else begin
            tog_ff <= !tog_ff;
            if (serValid && linkReady) begin
                shift_ff <= {shift_ff[62:0], serData};
                cnt_ff   <= serFirst ? 7'h01 : cnt_ff + 7'h01;
                if (!serFirst && cnt_ff == 7'h3f) begin
                    frameWord  <= {shift_ff[62:0], serData};
                    frameCount <= frameCount + 1;
                end
            end
        end
    end
endmodule

// >>> bench/test_rx_strength_status.sv
// self-checking bench for the strength and status readout.
// assumes link_sink on the far side and the bound port checker.
`timescale 1ns/10ps
module test_rx_strength_status;
    logic        core_clk, rst, regWrEn, regRdEn, sampleValid, lnaLowGain, gainUpEvt, gainDownEvt;
    logic        gainHoldPin, gainHold, gainApply, linkReady, serValid, serData, serFirst, frameDropped;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic [23:0] sampleI, sampleQ;
    logic [5:0]  pgaGainI, pgaGainQ;
    logic [4:0]  testFlags;
    logic [1:0]  pace;
    logic [63:0] frameWord, f;
    int          frameCount, n_errors, n_checks, cyc, nApply, i, t0, t1;
    logic [15:0] regTab [6] = '{16'h1f01, 16'h2100, 16'h2200, 16'h2c00, 16'h4b00, 16'h5500};
    logic [19:0] rateTab [4] = '{20'h00080, 20'h64200, 20'h08100, 20'h89800};
    rx_strength_status dut_u (.core_clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .sampleValid, .sampleI, .sampleQ, .pgaGainI, .pgaGainQ, .lnaLowGain, .gainUpEvt, .gainDownEvt, .gainHoldPin,
        .testFlags, .gainHold, .gainApply, .linkReady, .serValid, .serData, .serFirst, .frameDropped);
    link_sink sink_u (.core_clk, .rst, .pace, .serValid, .serData, .serFirst, .linkReady, .frameWord, .frameCount);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (gainApply === 1'b1) nApply++;
    end
    // ----
    // access and compare tasks
    // ----
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bound(input int k);
        if (k >= 5000) begin
            check("wait", 64'h1, 64'h0);
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rdck(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        {regAddr, regRdEn} = {a, 1'b1};
        @(negedge core_clk);
        regRdEn = 1'b0;
        @(negedge core_clk);
        check($sformatf("reg %h", a), 64'(e), 64'(regRdData));
    endtask
    task automatic next_frame();
        int k, n0;
        n0 = frameCount;
        for (k = 0; k < 5000 && frameCount == n0; k++) @(negedge core_clk);
        bound(k);
        f = frameWord;
    endtask
    task automatic first_at(output int t);
        int k;
        for (k = 0; k < 5000 && serFirst === 1'b1; k++) @(negedge core_clk);
        for (k = 0; k < 5000 && serFirst !== 1'b1; k++) @(negedge core_clk);
        bound(k);
        t = cyc;
    endtask
    task automatic pulse(input logic up);
        {gainUpEvt, gainDownEvt} = {up, !up};
        @(negedge core_clk);
        {gainUpEvt, gainDownEvt} = 2'b00;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {rst, regWrEn, regRdEn, sampleValid, lnaLowGain, gainUpEvt, gainDownEvt, gainHoldPin} = 8'h80;
        {regAddr, regWrData, sampleI, sampleQ} = {16'h0000, 24'habcdef, 24'h123456};
        {pgaGainI, pgaGainQ, testFlags, pace} = {6'h30, 6'h2a, 5'h1f, 2'h0};
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        wr(8'h3a, 8'hff);
        rdck(8'h3a, 8'h00);
        foreach (regTab[i]) rdck(regTab[i][15:8], regTab[i][7:0]);
        lnaLowGain = 1'b1;
        rdck(8'h2f, 8'h70);
        rdck(8'h30, 8'h2a);
        repeat (130) @(negedge core_clk);
        rdck(8'h3a, 8'hfe);
        $display("test registers done");
        sampleValid = 1'b1;
        wr(8'h4b, 8'h0e);
        next_frame();
        pulse(1'b1);
        next_frame();
        check("frame data", 64'h0000abcdef123456, 64'(f[63:16]));
        check("flags up", 64'h037e, 64'(f[15:0]));
        pulse(1'b0);
        next_frame();
        check("flags down", 64'h02fe, 64'(f[15:0]));
        wr(8'h4b, 8'h00);
        next_frame();
        next_frame();
        check("flags masked", 64'h0, 64'(f[15:0]));
        $display("test status flags done");
        wr(8'h4b, 8'h04);
        wr(8'h21, 8'h08);
        wr(8'h1f, 8'h05);
        gainHoldPin = 1'b1;
        next_frame();
        pulse(1'b1);
        next_frame();
        check("flag pending", 64'h0, 64'(f[15:0]));
        wr(8'h1f, 8'h07);
        check("hold on", 64'h1, 64'(gainHold));
        next_frame();
        check("flag at hold", 64'h0100, 64'(f[15:0]));
        wr(8'h1f, 8'h05);
        @(negedge core_clk);
        check("apply pulses", 64'h1, 64'(nApply));
        check("hold by bit", 64'h0, 64'(gainHold));
        wr(8'h1f, 8'h01);
        check("hold by pin", 64'h1, 64'(gainHold));
        gainHoldPin = 1'b0;
        $display("test gain hold done");
        for (i = 0; i < 4; i++) begin
            pace = (i == 1) ? 2'h1 : 2'h0;
            wr(8'h22, rateTab[i][19:12]);
            first_at(t0);
            first_at(t0);
            first_at(t1);
            check("frame period", 64'(rateTab[i][11:0]), 64'(t1 - t0));
        end
        $display("test rates done");
        wr(8'h22, 8'h00);
        pace = 2'h2;
        repeat (1200) @(negedge core_clk);
        pace = 2'h0;
        repeat (2000) @(negedge core_clk);
        check("dropped", 64'h1, 64'(frameDropped));
        wr(8'h4b, 8'h00);
        check("dropped clear", 64'h0, 64'(frameDropped));
        $display("test buffer done");
        wrap_up();
    end
endmodule
